// File: include/abh_defines.vh
// Constants for the alarm buffer and history block
`ifndef ABH_DEFINES_VH
`define ABH_DEFINES_VH

// Sizes
`define ABH_BUF_DEPTH 8
`define ABH_TOTAL_DEPTH 64
`define ABH_HIST_FIRST 8
`define ABH_HIST_LAST 63
`define ABH_CODE_W 16
`define ABH_VAL_W 32
`define ABH_CNT_W 16
`define ABH_OVERWRITE_SLOT 3'h6
`define ABH_BUF_FULL 8'hFF

// Register byte offsets
`define ABH_REG_STATUS_WORD 12'h000
`define ABH_REG_COUNTER 12'h004
`define ABH_REG_LATEST 12'h008
`define ABH_REG_IRQ_STATUS 12'h00C
`define ABH_REG_IRQ_MASK 12'h010
`define ABH_REG_BUF_STATE 12'h014
`define ABH_REG_HIST_STATE_LO 12'h018
`define ABH_REG_HIST_STATE_HI 12'h01C

// Array windows, selected by address bits 9:8, entry in bits 7:2
`define ABH_WIN_CTRL 2'h0
`define ABH_WIN_CODE 2'h1
`define ABH_WIN_FIXED 2'h2
`define ABH_WIN_FLOAT 2'h3

// Field positions
`define ABH_STAT_PRESENT_BIT 7
`define ABH_IRQ_W 3
`define ABH_IRQ_NEW 0
`define ABH_IRQ_XFER 1
`define ABH_IRQ_OVWR 2
`define ABH_IRQ_MASK_RST 3'h0

`endif

// File: core/abh_alarm_buffer.v
// Alarm buffer, alarm history and their APB register file
//
// Function
// RQ1: Alarms clear themselves, no acknowledge needed
// RQ2: Status word bit 7 shows alarm present
// RQ3: Store code and value per alarm
// RQ4: Fixed and float values share code index
// RQ5: Removed alarms stay, only marked removed
// RQ6: Count each alarm; older entries stay put
// RQ7: Buffer has eight entries, 0 to 7
// RQ8: Full with none removed: overwrite second-newest
// RQ9: History holds 56 entries
// RQ10: Only removed entries enter the history
// RQ11: Alarm into full buffer moves removed entries
// RQ12: History newest first from index 8
// RQ13: Active entries compacted without gaps
// RQ14: Oldest history entry dropped beyond 63
// RQ15: Counter write of zero moves removed entries
// RQ16: Read-only code of latest alarm
// RQ17: New alarm at lowest free; history shifts up
// RQ18: Code and both values move together
//
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/1ps
`include "abh_defines.vh"

module abh_alarm_buffer (
  input wire clock,
  input wire rst_b,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  input wire alarm_valid,
  input wire [`ABH_CODE_W-1:0] alarm_code,
  input wire [`ABH_VAL_W-1:0] alarm_fixed,
  input wire [`ABH_VAL_W-1:0] alarm_float,
  input wire alarm_gone,
  input wire [`ABH_CODE_W-1:0] alarm_gone_code,
  output wire alarm_present,
  output wire irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function [3:0] abh_count8;
    input [7:0] v;
    integer n;
    begin
      abh_count8 = 4'h0;
      for (n = 0; n < `ABH_BUF_DEPTH; n = n + 1) begin
        abh_count8 = abh_count8 + {3'h0, v[n]};
      end
    end
  endfunction

  function abh_reg_hit;
    input [11:0] a;
    input [11:0] off;
    begin
      abh_reg_hit = (a == off);
    end
  endfunction

  function abh_mapped;
    input [11:0] a;
    begin
      if (a[11:10] != 2'h0 || a[1:0] != 2'h0) begin
        abh_mapped = 1'b0;
      end else if (a[9:8] != `ABH_WIN_CTRL) begin
        abh_mapped = 1'b1;
      end else begin
        abh_mapped = (a[7:0] <= `ABH_REG_HIST_STATE_HI);
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  // Entries 0..7 are the buffer, 8..63 the history; one occupied bit each
  reg [`ABH_CODE_W-1:0] code_reg [0:`ABH_TOTAL_DEPTH-1]; // [RQ7] [RQ9]
  reg [`ABH_VAL_W-1:0] fix_reg [0:`ABH_TOTAL_DEPTH-1];
  reg [`ABH_VAL_W-1:0] flt_reg [0:`ABH_TOTAL_DEPTH-1];
  reg [`ABH_CODE_W-1:0] code_next [0:`ABH_TOTAL_DEPTH-1];
  reg [`ABH_VAL_W-1:0] fix_next [0:`ABH_TOTAL_DEPTH-1];
  reg [`ABH_VAL_W-1:0] flt_next [0:`ABH_TOTAL_DEPTH-1];
  reg [`ABH_TOTAL_DEPTH-1:0] occ_reg;
  reg [`ABH_TOTAL_DEPTH-1:0] occ_next;
  reg [`ABH_BUF_DEPTH-1:0] rem_reg;
  reg [`ABH_BUF_DEPTH-1:0] rem_next;
  reg [`ABH_CNT_W-1:0] cnt_reg;
  reg [`ABH_CODE_W-1:0] latest_reg;
  reg [`ABH_IRQ_W-1:0] irq_stat_reg;
  reg [`ABH_IRQ_W-1:0] irq_mask_reg;
  reg [`ABH_CNT_W-1:0] cnt_next;
  reg [`ABH_CODE_W-1:0] latest_next;
  reg [`ABH_IRQ_W-1:0] irq_stat_next;
  reg [`ABH_IRQ_W-1:0] irq_mask_next;
  reg [`ABH_IRQ_W-1:0] irq_set;
  reg [`ABH_IRQ_W-1:0] irq_clr;

  reg [`ABH_BUF_DEPTH-1:0] gone_hit;
  reg [`ABH_BUF_DEPTH-1:0] rem_work;
  reg do_xfer;
  reg overwrite;
  reg [3:0] nrem;
  reg [2:0] slot;
  reg [3:0] nfill;
  reg [31:0] rd_mux;
  integer i;
  integer j;
  integer k;
  integer w;
  integer g;
  integer p;

  wire apb_setup;
  wire apb_wr;
  wire apb_rd;
  wire wr_cnt;
  wire clr_xfer;
  wire wr_mask;
  wire rd_irq;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  // Zero wait states: data is captured in the setup cycle
  assign pready = 1'b1;
  assign apb_setup = psel & ~penable;
  assign apb_wr = psel & penable & pwrite & ~pslverr;
  assign apb_rd = psel & penable & ~pwrite & ~pslverr;
  assign wr_cnt = apb_wr && abh_reg_hit(paddr, `ABH_REG_COUNTER);
  assign wr_mask = apb_wr && abh_reg_hit(paddr, `ABH_REG_IRQ_MASK);
  assign rd_irq = apb_rd && abh_reg_hit(paddr, `ABH_REG_IRQ_STATUS);
  assign clr_xfer = wr_cnt && pwdata[`ABH_CNT_W-1:0] == {`ABH_CNT_W{1'b0}}; // [RQ15]

  ////////////////////////////////////////////////////////////////////////////
  // Alarm removal: the source drops the alarm, no acknowledge involved

  always @* begin
    for (g = 0; g < `ABH_BUF_DEPTH; g = g + 1) begin
      gone_hit[g] = alarm_gone & occ_reg[g] & ~rem_reg[g] & (code_reg[g] == alarm_gone_code); // [RQ1]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next contents of buffer and history

  always @* begin
    for (i = 0; i < `ABH_TOTAL_DEPTH; i = i + 1) begin
      code_next[i] = code_reg[i];
      fix_next[i] = fix_reg[i];
      flt_next[i] = flt_reg[i];
    end
    occ_next = occ_reg;
    // Entry is only flagged, never erased here
    rem_work = rem_reg | gone_hit; // [RQ5]
    rem_next = rem_work;
    do_xfer = clr_xfer | (alarm_valid & (occ_reg[`ABH_BUF_DEPTH-1:0] == `ABH_BUF_FULL)); // [RQ11] [RQ15]
    nrem = abh_count8(occ_reg[`ABH_BUF_DEPTH-1:0] & rem_work);
    overwrite = 1'b0;
    slot = 3'h0;
    nfill = 4'h0;
    j = 0;
    k = `ABH_HIST_FIRST;
    w = 0;
    if (do_xfer) begin
      // Whole move in one cycle: wide muxes, but no half-moved state is ever readable
      // Old history moves up by the number moved in; past 63 falls off
      for (j = `ABH_HIST_LAST; j >= `ABH_HIST_FIRST; j = j - 1) begin
        if (j - nrem >= `ABH_HIST_FIRST) begin // [RQ14] [RQ17]
          code_next[j] = code_reg[j - nrem]; // [RQ18]
          fix_next[j] = fix_reg[j - nrem];
          flt_next[j] = flt_reg[j - nrem];
          occ_next[j] = occ_reg[j - nrem];
        end
      end
      // Youngest removed alarm lands at index 8
      for (i = `ABH_BUF_DEPTH - 1; i >= 0; i = i - 1) begin
        if (occ_reg[i] & rem_work[i]) begin // [RQ10]
          code_next[k] = code_reg[i]; // [RQ12] [RQ18]
          fix_next[k] = fix_reg[i];
          flt_next[k] = flt_reg[i];
          occ_next[k] = 1'b1;
          k = k + 1;
        end
      end
      // Active alarms close up toward index 0
      occ_next[`ABH_BUF_DEPTH-1:0] = {`ABH_BUF_DEPTH{1'b0}};
      rem_next = {`ABH_BUF_DEPTH{1'b0}};
      for (i = 0; i < `ABH_BUF_DEPTH; i = i + 1) begin
        if (occ_reg[i] & ~rem_work[i]) begin // [RQ13]
          code_next[w] = code_reg[i]; // [RQ18]
          fix_next[w] = fix_reg[i];
          flt_next[w] = flt_reg[i];
          occ_next[w] = 1'b1;
          w = w + 1;
        end
      end
    end
    if (alarm_valid) begin
      // Buffer fills from 0 upward, so the occupied count is the next slot
      if (occ_next[`ABH_BUF_DEPTH-1:0] == `ABH_BUF_FULL) begin
        overwrite = 1'b1;
        slot = `ABH_OVERWRITE_SLOT; // [RQ8]
      end else begin
        nfill = abh_count8(occ_next[`ABH_BUF_DEPTH-1:0]);
        slot = nfill[2:0]; // [RQ17] [RQ7]
      end
      code_next[slot] = alarm_code; // [RQ3]
      fix_next[slot] = alarm_fixed; // [RQ4]
      flt_next[slot] = alarm_float; // [RQ4]
      occ_next[slot] = 1'b1; // [RQ6]
      rem_next[slot] = 1'b0;
    end
  end

  // Payload arrays need no reset: the occupied bits qualify them
  always @(posedge clock) begin
    for (p = 0; p < `ABH_TOTAL_DEPTH; p = p + 1) begin
      code_reg[p] <= code_next[p];
      fix_reg[p] <= fix_next[p];
      flt_reg[p] <= flt_next[p];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter, latest code and interrupt next values

  always @* begin
    cnt_next = cnt_reg;
    latest_next = latest_reg;
    irq_mask_next = irq_mask_reg;
    // An alarm in the same cycle as a software write still counts
    if (wr_cnt) begin
      cnt_next = pwdata[`ABH_CNT_W-1:0] + {{(`ABH_CNT_W-1){1'b0}}, alarm_valid}; // [RQ6]
    end else if (alarm_valid) begin
      cnt_next = cnt_reg + {{(`ABH_CNT_W-1){1'b0}}, 1'b1}; // [RQ6]
    end
    if (alarm_valid) begin
      latest_next = alarm_code; // [RQ16]
    end
    if (wr_mask) begin
      irq_mask_next = pwdata[`ABH_IRQ_W-1:0];
    end
    // Clear only what the read returned, so an event after setup is not lost
    irq_clr = rd_irq ? prdata[`ABH_IRQ_W-1:0] : {`ABH_IRQ_W{1'b0}};
    irq_set = {overwrite, do_xfer, alarm_valid};
    // Set wins over the clear in the same cycle
    irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_set;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control state, counter and interrupts

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      occ_reg <= {`ABH_TOTAL_DEPTH{1'b0}};
      rem_reg <= {`ABH_BUF_DEPTH{1'b0}};
    end else begin
      occ_reg <= occ_next;
      rem_reg <= rem_next;
    end
  end

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= {`ABH_CNT_W{1'b0}};
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      latest_reg <= {`ABH_CODE_W{1'b0}};
    end else begin
      latest_reg <= latest_next;
    end
  end

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      irq_stat_reg <= {`ABH_IRQ_W{1'b0}};
      irq_mask_reg <= `ABH_IRQ_MASK_RST;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
    end
  end

  assign alarm_present = |(occ_reg[`ABH_BUF_DEPTH-1:0] & ~rem_reg); // [RQ2] [RQ1]
  assign irq = |(irq_stat_reg & irq_mask_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  always @* begin
    rd_mux = 32'h0000_0000;
    case (paddr[9:8])
      `ABH_WIN_CODE: rd_mux = {{(32-`ABH_CODE_W){1'b0}}, code_reg[paddr[7:2]]};
      `ABH_WIN_FIXED: rd_mux = fix_reg[paddr[7:2]];
      `ABH_WIN_FLOAT: rd_mux = flt_reg[paddr[7:2]];
      default: begin
        case (paddr)
          `ABH_REG_STATUS_WORD: rd_mux[`ABH_STAT_PRESENT_BIT] = alarm_present; // [RQ2]
          `ABH_REG_COUNTER: rd_mux = {{(32-`ABH_CNT_W){1'b0}}, cnt_reg};
          `ABH_REG_LATEST: rd_mux = {{(32-`ABH_CODE_W){1'b0}}, latest_reg}; // [RQ16]
          `ABH_REG_IRQ_STATUS: rd_mux = {{(32-`ABH_IRQ_W){1'b0}}, irq_stat_reg};
          `ABH_REG_IRQ_MASK: rd_mux = {{(32-`ABH_IRQ_W){1'b0}}, irq_mask_reg};
          `ABH_REG_BUF_STATE: rd_mux = {16'h0000, rem_reg, occ_reg[`ABH_BUF_DEPTH-1:0]};
          `ABH_REG_HIST_STATE_LO: rd_mux = occ_reg[31:0];
          `ABH_REG_HIST_STATE_HI: rd_mux = occ_reg[63:32];
          default: rd_mux = 32'h0000_0000;
        endcase
      end
    endcase
  end

  // Data and error are captured in setup and held through access
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else if (apb_setup) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_mux;
    end
  end

  // Error depends on the address alone, so reads and writes agree
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pslverr <= 1'b0;
    end else if (apb_setup) begin
      pslverr <= ~abh_mapped(paddr);
    end
  end

endmodule

// File: dv/abh_alarm_properties.sv
// Port assertions for the alarm buffer and history
`timescale 1ns/1ps
module abh_alarm_properties (
  input wire clock,
  input wire rst_b,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire alarm_valid,
  input wire alarm_gone,
  input wire alarm_present,
  input wire irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////
  sequence access_s;
    psel && penable;
  endsequence
  sequence to_unmapped_s;
    (psel && !penable && paddr[11:10] != 2'h0) ##1 access_s;
  endsequence
  sequence to_latest_s;
    (psel && !penable && paddr == 12'h008) ##1 access_s;
  endsequence
  zero_wait_a: assert property (access_s |-> pready)
    else $error("pready low in access phase");
  read_hold_a: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("read data changed outside setup");
  unmapped_err_a: assert property (to_unmapped_s |-> pslverr)
    else $error("no error for unmapped address");
  latest_ok_a: assert property (to_latest_s |-> !pslverr)
    else $error("error on latest code read");
  present_set_a: assert property (alarm_valid |=> alarm_present)
    else $error("present low after new alarm");
  present_rise_a: assert property ($rose(alarm_present) |-> $past(alarm_valid))
    else $error("present rose without alarm");
  present_fall_a: assert property ($fell(alarm_present) |-> $past(alarm_gone))
    else $error("present fell without cause gone");
  irq_cause_a: assert property ($rose(irq) |-> $past(alarm_valid || (psel && penable && pwrite)))
    else $error("irq rose without event or write");
endmodule
bind abh_alarm_buffer abh_alarm_properties i_abh_alarm_properties (.clock(clock), .rst_b(rst_b),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .alarm_valid(alarm_valid), .alarm_gone(alarm_gone),
  .alarm_present(alarm_present), .irq(irq));

// File: dv/abh_testbench.sv
// Self-checking bench for the alarm buffer and history
`timescale 1ns/1ps
`include "abh_defines.vh"
module testbench;
  reg clock = 1'h0;
  reg rst_b = 1'h0;
  reg psel = 1'h0;
  reg penable = 1'h0;
  reg pwrite = 1'h0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  reg alarm_valid = 1'h0;
  reg alarm_gone = 1'h0;
  reg [15:0] alarm_code = 16'h0;
  reg [15:0] alarm_gone_code = 16'h0;
  reg [31:0] alarm_fixed = 32'h0;
  reg [31:0] alarm_float = 32'h0;
  wire [31:0] prdata;
  wire pready, pslverr, alarm_present, irq;
  integer err_total = 0;
  integer samples_checked = 0;
  integer i;
  reg [31:0] rd;
  reg err;
  reg [111:0] cq = {16'h0010, 16'h0011, 16'h0013, 16'h0014, 16'h0020, 16'h0017, 16'h0030};
  always #4 clock = ~clock;
  abh_alarm_buffer i_abh_alarm_buffer (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .alarm_valid(alarm_valid), .alarm_code(alarm_code), .alarm_fixed(alarm_fixed),
    .alarm_float(alarm_float), .alarm_gone(alarm_gone), .alarm_gone_code(alarm_gone_code),
    .alarm_present(alarm_present), .irq(irq));
  ////////////////////////////////////////
  task check(input [31:0] got, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge clock);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'h1;
      @(posedge clock);
      for (n = 0; pready !== 1'h1; n = n + 1) begin
        if (n == 16) begin
          err_total = err_total + 1;
          $display("ERROR %0t: no pready", $time);
          finish_test;
        end
        @(posedge clock);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
    end
  endtask
  task rc(input [11:0] a, input [31:0] exp);
    begin
      apb(1'h0, a, 32'h0);
      check(rd, exp);
    end
  endtask
  // Code, fixed and float views of one entry must agree
  task ent(input [5:0] i, input [15:0] c);
    begin
      rc(12'h100 + {4'h0, i, 2'h0}, {16'h0, c});
      rc(12'h200 + {4'h0, i, 2'h0}, {16'hA5A5, c});
      rc(12'h300 + {4'h0, i, 2'h0}, {c, 16'h3C00});
    end
  endtask
  task ev(input g, input [15:0] c);
    begin
      @(posedge clock);
      alarm_valid <= !g;
      alarm_gone <= g;
      alarm_code <= c;
      alarm_gone_code <= c;
      alarm_fixed <= {16'hA5A5, c};
      alarm_float <= {c, 16'h3C00};
      @(posedge clock);
      alarm_valid <= 1'h0;
      alarm_gone <= 1'h0;
    end
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clock);
    rst_b <= 1'h1;
    rc(`ABH_REG_STATUS_WORD, 32'h0);
    ev(1'h0, 16'h0101);
    ev(1'h0, 16'h0202);
    rc(`ABH_REG_STATUS_WORD, 32'h80);
    check({31'h0, alarm_present}, 32'h1);
    ent(6'h0, 16'h0101);
    ent(6'h1, 16'h0202);
    rc(`ABH_REG_COUNTER, 32'h2);
    rc(`ABH_REG_LATEST, 32'h0202);
    ev(1'h1, 16'h0101);
    rc(`ABH_REG_BUF_STATE, 32'h0103);
    ent(6'h0, 16'h0101);
    ev(1'h1, 16'h0202);
    rc(`ABH_REG_STATUS_WORD, 32'h0);
    check({31'h0, alarm_present}, 32'h0);
    $display("test store done");
    apb(1'h1, `ABH_REG_COUNTER, 32'h0);
    ent(6'h8, 16'h0202);
    ent(6'h9, 16'h0101);
    rc(`ABH_REG_BUF_STATE, 32'h0);
    $display("test clear done");
    for (i = 0; i < 8; i = i + 1)
      ev(1'h0, 16'h0010 + i[15:0]);
    rc(`ABH_REG_BUF_STATE, 32'h00FF);
    ev(1'h0, 16'h0020);
    ent(6'h6, 16'h0020);
    ent(6'h7, 16'h0017);
    ev(1'h1, 16'h0012);
    ev(1'h1, 16'h0015);
    ev(1'h0, 16'h0030);
    rc(`ABH_REG_COUNTER, 32'hA);
    ent(6'h8, 16'h0015);
    ent(6'h9, 16'h0012);
    ent(6'hA, 16'h0202);
    ent(6'hB, 16'h0101);
    for (i = 0; i < 7; i = i + 1)
      ent(i[5:0], cq[111 - 16 * i -: 16]);
    rc(`ABH_REG_HIST_STATE_LO, 32'h00000F7F);
    rc(`ABH_REG_HIST_STATE_HI, 32'h0);
    $display("test history done");
    apb(1'h0, `ABH_REG_IRQ_STATUS, 32'h0);
    apb(1'h1, `ABH_REG_IRQ_MASK, 32'h1);
    ev(1'h0, 16'h0040);
    @(posedge clock);
    check({31'h0, irq}, 32'h1);
    rc(`ABH_REG_IRQ_STATUS, 32'h1);
    @(posedge clock);
    check({31'h0, irq}, 32'h0);
    apb(1'h1, `ABH_REG_IRQ_MASK, 32'h0);
    ev(1'h0, 16'h0041);
    @(posedge clock);
    check({31'h0, irq}, 32'h0);
    rc(`ABH_REG_IRQ_STATUS, 32'h7);
    ent(6'h6, 16'h0041);
    $display("test irq done");
    apb(1'h1, 12'h400, 32'h1234);
    check({31'h0, err}, 32'h1);
    rc(12'h400, 32'h0);
    check({31'h0, err}, 32'h1);
    apb(1'h1, `ABH_REG_LATEST, 32'h5555);
    rc(`ABH_REG_LATEST, 32'h0041);
    $display("test access done");
    for (i = 0; i < 60; i = i + 1) begin
      ev(1'h0, 16'h0100 + i[15:0]);
      ev(1'h1, 16'h0100 + i[15:0]);
    end
    ent(6'h8, 16'h013A);
    ent(6'h3F, 16'h0103);
    rc(`ABH_REG_HIST_STATE_HI, 32'hFFFFFFFF);
    rc(`ABH_REG_BUF_STATE, 32'h80FF);
    $display("test wrap done");
    finish_test;
  end
endmodule
